//--- hdl/dtg_pkg.sv
// Constants for the keypad-driven dual-tone generator
//
// Function
// - One key gives row plus column tones
// - Tone suppress low mutes every combination
// - Singles permit low blocks lone tones
// - Singles permit high allows single tones
// - Key flag pulls low on any key
// - Lone column gives that column tone
// - Several columns give no column tone
// - Rows without a column give nothing
// - Lone row needs row plus two columns
// - Eight tones divided from crystal reference
// - Row tones 701.3 771.4 857.2 935.1
// - Column tones 1215.9 1331.7 1471.9 1645.0
// - Stepped sines summed into one output
// - Output settles within five milliseconds
package dtg_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int STEPS = 16; // Sine steps per period
  localparam int RISE_MS = 5; // Longest settling time
  localparam int RISE_CYC = RISE_MS * (CLK_HZ / 1000);
  // Tones in tenths of a hertz
  localparam int ROW_DHZ [4] = '{7013, 7714, 8572, 9351};
  localparam int COL_DHZ [4] = '{12159, 13317, 14719, 16450};
  // ----------------------------------------
  // Reset values and levels
  // ----------------------------------------
  localparam logic [7:0] MID_LEVEL = 8'h80;
  localparam logic [3:0] LINES_IDLE = 4'hF;
  // Phase step divider: cycles per sine step, rounded to nearest
  function automatic logic [15:0] step_div(input int dhz);
    step_div = 16'((CLK_HZ * 10 / STEPS + dhz / 2) / dhz);
  endfunction
endpackage

//--- hdl/dtg_top.sv
// Keypad-driven dual-tone multi-frequency generator
module dtg_top (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] row_n_i,
  input wire logic [3:0] col_n_i,
  input wire logic tone_off_n_i,
  input wire logic single_ok_i,
  output logic key_flag_o,
  output logic key_flag_oe_o,
  output logic tone_valid_o,
  output logic [7:0] tone_o
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] row_m;
    logic [3:0] row_s;
    logic [3:0] col_m;
    logic [3:0] col_s;
    logic [1:0] ctl_m;
    logic [1:0] ctl_s;
    logic [15:0] rcnt;
    logic [15:0] ccnt;
    logic [3:0] rph;
    logic [3:0] cph;
    logic ron;
    logic con;
    logic [7:0] out;
  } dtg_st_t;
  dtg_st_t st;
  dtg_st_t next_st;

  // Stepped sine, 16 steps, signed amplitude around zero
  function automatic logic signed [6:0] sine(input logic [3:0] p);
    case (p)
      4'h0: sine = 7'sd0;
      4'h1: sine = 7'sd24;
      4'h2: sine = 7'sd45;
      4'h3: sine = 7'sd59;
      4'h4: sine = 7'sd63;
      4'h5: sine = 7'sd59;
      4'h6: sine = 7'sd45;
      4'h7: sine = 7'sd24;
      4'h8: sine = 7'sd0;
      4'h9: sine = -7'sd24;
      4'hA: sine = -7'sd45;
      4'hB: sine = -7'sd59;
      4'hC: sine = -7'sd63;
      4'hD: sine = -7'sd59;
      4'hE: sine = -7'sd45;
      default: sine = -7'sd24;
    endcase
  endfunction

  function automatic logic [1:0] idx(input logic [3:0] v);
    case (v)
      4'b0010: idx = 2'd1;
      4'b0100: idx = 2'd2;
      4'b1000: idx = 2'd3;
      default: idx = 2'd0;
    endcase
  endfunction

  logic [3:0] row_a;
  logic [3:0] col_a;
  logic [2:0] ncol;
  logic [2:0] nrow;
  logic any_key;
  logic want_r;
  logic want_c;
  logic [15:0] rdiv;
  logic [15:0] cdiv;
  logic signed [8:0] mix;

  // ----------------------------------------
  // Key decode
  // ----------------------------------------
  // Decode active lines; keypad pulls lines low
  always_comb begin
    row_a = ~st.row_s;
    col_a = ~st.col_s;
    ncol = 3'(col_a[0]) + 3'(col_a[1]) + 3'(col_a[2]) + 3'(col_a[3]);
    nrow = 3'(row_a[0]) + 3'(row_a[1]) + 3'(row_a[2]) + 3'(row_a[3]);
    any_key = (ncol != 3'd0) || (nrow != 3'd0);
    // Column needed for anything; several columns kill it
    want_c = (ncol == 3'd1) && (nrow <= 3'd1);
    // Row tone with its column, or lone row with two columns
    want_r = (nrow == 3'd1) && ((ncol == 3'd1) || (ncol == 3'd2));
    // Lone tones only when singles are permitted
    if (!st.ctl_s[1] && !(want_r && want_c)) begin
      want_r = 1'b0;
      want_c = 1'b0;
    end
    // Suppress input mutes everything
    if (!st.ctl_s[0]) begin
      want_r = 1'b0;
      want_c = 1'b0;
    end
    rdiv = dtg_pkg::step_div(dtg_pkg::ROW_DHZ[idx(row_a)]);
    cdiv = dtg_pkg::step_div(dtg_pkg::COL_DHZ[idx(col_a)]);
  end

  // ----------------------------------------
  // Synthesis
  // ----------------------------------------
  // Next state: synchronise, divide, step and mix
  always_comb begin
    next_st = st;
    // Two-flop synchronisers for the pins
    next_st.row_m = row_n_i;
    next_st.row_s = st.row_m;
    next_st.col_m = col_n_i;
    next_st.col_s = st.col_m;
    next_st.ctl_m = {single_ok_i, tone_off_n_i};
    next_st.ctl_s = st.ctl_m;
    next_st.ron = want_r;
    next_st.con = want_c;
    // Separate row and column dividers
    if (!want_r) begin
      next_st.rcnt = '0; // Idle with no key
      next_st.rph = '0;
    end else if (st.rcnt + 16'd1 >= rdiv) begin
      next_st.rcnt = '0;
      next_st.rph = st.rph + 4'd1;
    end else begin
      next_st.rcnt = st.rcnt + 16'd1;
    end
    if (!want_c) begin
      next_st.ccnt = '0;
      next_st.cph = '0;
    end else if (st.ccnt + 16'd1 >= cdiv) begin
      next_st.ccnt = '0;
      next_st.cph = st.cph + 4'd1;
    end else begin
      next_st.ccnt = st.ccnt + 16'd1;
    end
    // Sum both stepped sines; row kept smaller as pre-emphasis
    mix = 9'sd0;
    if (st.ron) begin
      mix = mix + 9'(sine(st.rph) >>> 1) + 9'(sine(st.rph) >>> 2);
    end
    if (st.con) begin
      mix = mix + 9'(sine(st.cph));
    end
    // Tone appears within a few cycles, far inside the limit
    next_st.out = 8'(9'sd128 + mix);
  end

  // State register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
      st.row_m <= dtg_pkg::LINES_IDLE;
      st.row_s <= dtg_pkg::LINES_IDLE;
      st.col_m <= dtg_pkg::LINES_IDLE;
      st.col_s <= dtg_pkg::LINES_IDLE;
      st.ctl_m <= 2'b01;
      st.ctl_s <= 2'b01;
      st.out <= dtg_pkg::MID_LEVEL;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Open-drain key flag, independent of suppress inputs
  assign key_flag_o = 1'b0;
  assign key_flag_oe_o = any_key;
  assign tone_valid_o = st.ron | st.con;
  assign tone_o = st.out;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Watch the synced lines, so pin glitches cannot trip them
  chk_flag_follows_key: assert property (@(posedge clk_i)
    disable iff (!nrst_i) key_flag_oe_o == (st.row_s != 4'hF
      || st.col_s != 4'hF)) else $error("key flag mismatch");
  chk_suppress_mutes: assert property (@(posedge clk_i)
    disable iff (!nrst_i) !st.ctl_s[0] |=> !tone_valid_o)
    else $error("tone while suppressed");
  chk_no_column_none: assert property (@(posedge clk_i)
    disable iff (!nrst_i) st.col_s == 4'hF |=> !tone_valid_o)
    else $error("tone with no column");
  chk_multi_col_off: assert property (@(posedge clk_i)
    disable iff (!nrst_i) ncol >= 3'd2 |=> !st.con)
    else $error("column tone on many columns");
  chk_single_block: assert property (@(posedge clk_i)
    disable iff (!nrst_i) !st.ctl_s[1] |=> st.ron == st.con)
    else $error("lone tone while blocked");
  chk_dual_tone: assert property (@(posedge clk_i)
    disable iff (!nrst_i) (st.ctl_s == 2'b01 && nrow == 3'd1
      && ncol == 3'd1) |=> st.ron && st.con)
    else $error("no dual tone for one key");
  chk_lone_row: assert property (@(posedge clk_i)
    disable iff (!nrst_i) (st.ctl_s == 2'b11 && nrow == 3'd1
      && ncol == 3'd2) |=> st.ron && !st.con)
    else $error("lone row tone missing");
  chk_lone_col: assert property (@(posedge clk_i)
    disable iff (!nrst_i) (st.ctl_s == 2'b11 && nrow == 3'd0
      && ncol == 3'd1) |=> st.con && !st.ron)
    else $error("lone column tone missing");
  chk_idle_quiet: assert property (@(posedge clk_i)
    disable iff (!nrst_i) !tone_valid_o |=> tone_o == 8'h80)
    else $error("output not quiet when idle");
  chk_singles_dual: assert property (@(posedge clk_i)
    disable iff (!nrst_i) (st.ctl_s == 2'b11 && nrow == 3'd1
      && ncol == 3'd1) |=> st.ron && st.con)
    else $error("no dual tone with singles allowed");
  chk_idle_counters: assert property (@(posedge clk_i)
    disable iff (!nrst_i) (!want_r && !want_c) |=> (st.rcnt == 16'h0000
      && st.ccnt == 16'h0000 && st.rph == 4'h0 && st.cph == 4'h0))
    else $error("synthesis counters not idle");
  chk_phase_steps: assert property (@(posedge clk_i)
    disable iff (!nrst_i) (st.ron && want_r) |=> (st.rph == $past(st.rph)
      || st.rph == $past(st.rph) + 4'd1))
    else $error("row phase skipped a step");
  chk_tone_prompt: assert property (@(posedge clk_i)
    disable iff (!nrst_i) (want_r || want_c) |=> tone_valid_o)
    else $error("tone late after key");
endmodule

//--- verif/dtg_keypad.sv
// Keypad partner model driving the active-low row and column lines
module dtg_keypad (
  input wire logic [3:0] row_press_i,
  input wire logic [3:0] col_press_i,
  output logic [3:0] row_n_o,
  output logic [3:0] col_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pressed lines pulled low; idle lines rest at the pull-up level
  assign row_n_o = ~row_press_i;
  assign col_n_o = ~col_press_i;
endmodule

//--- verif/testbench.sv
// Self-checking bench for the dual-tone generator
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, nrst_i, tone_off_n_i, single_ok_i;
  logic [3:0] row_press, col_press, row_n, col_n;
  logic key_flag_o, key_flag_oe_o, tone_valid_o;
  logic [7:0] tone_o;
  int num_errors, samples_checked;
  // ------------------------------------------------------------
  // Clock, partner and design
  // ------------------------------------------------------------
  // Bench clock stands in for the tone reference
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  dtg_keypad dtg_keypad_inst (.row_press_i(row_press),
    .col_press_i(col_press), .row_n_o(row_n), .col_n_o(col_n));
  dtg_top dtg_top_inst (.clk_i(clk_i), .nrst_i(nrst_i),
    .row_n_i(row_n), .col_n_i(col_n), .tone_off_n_i(tone_off_n_i),
    .single_ok_i(single_ok_i), .key_flag_o(key_flag_o),
    .key_flag_oe_o(key_flag_oe_o), .tone_valid_o(tone_valid_o),
    .tone_o(tone_o));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Case equality, so an unknown never passes
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Apply a key pattern, let the sync chain settle, check outputs
  task automatic keys(input logic [3:0] r, input logic [3:0] c,
                      input logic ok, input logic on, input logic vld);
    @(posedge clk_i);
    row_press <= r;
    col_press <= c;
    single_ok_i <= ok;
    tone_off_n_i <= on;
    repeat (6) @(posedge clk_i);
    #1;
    check({15'h0000, tone_valid_o}, {15'h0000, vld});
    check({15'h0000, key_flag_oe_o}, {15'h0000, (r | c) != 4'h0});
    check({15'h0000, key_flag_o}, 16'h0000);
    if (!vld) check({8'h00, tone_o}, 16'h0080);
  endtask
  // Second interval between sample changes is one full sine step
  task automatic step_len(input int dhz);
    int n;
    int want;
    logic [7:0] last;
    want = (dtg_pkg::CLK_HZ * 10 / dtg_pkg::STEPS + dhz / 2) / dhz;
    last = tone_o;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (tone_o === last && n < 8000) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      last = tone_o;
    end
    check(16'(n), 16'(want));
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    num_errors = 0;
    samples_checked = 0;
    nrst_i = 1'b0;
    row_press = 4'h0;
    col_press = 4'h0;
    tone_off_n_i = 1'b1;
    single_ok_i = 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    keys(4'h1, 4'h1, 1'b0, 1'b1, 1'b1);
    keys(4'h1, 4'h1, 1'b1, 1'b0, 1'b0);
    keys(4'h0, 4'h2, 1'b0, 1'b1, 1'b0);
    keys(4'h0, 4'h2, 1'b1, 1'b1, 1'b1);
    keys(4'h0, 4'h6, 1'b1, 1'b1, 1'b0);
    keys(4'h4, 4'h0, 1'b1, 1'b1, 1'b0);
    keys(4'h8, 4'h3, 1'b0, 1'b1, 1'b0);
    keys(4'h0, 4'h0, 1'b1, 1'b1, 1'b0);
    // Each tone alone, so its step length is seen cleanly
    for (int i = 0; i < 4; i++) begin
      keys(4'h0, 4'(1 << i), 1'b1, 1'b1, 1'b1);
      step_len(dtg_pkg::COL_DHZ[i]);
      keys(4'(1 << i), 4'h3, 1'b1, 1'b1, 1'b1);
      step_len(dtg_pkg::ROW_DHZ[i]);
    end
    report_and_stop();
  end
  // Tests need some 39k cycles; cut a hang well beyond that
  initial begin
    repeat (80000) @(posedge clk_i);
    num_errors++;
    report_and_stop();
  end
endmodule
